//--- common/jtp_pkg.sv
`default_nettype none

package jtp_pkg;

    // ----------------------------------------
    // widths and depths
    // ----------------------------------------
    localparam int DR_W = 8;
    localparam int IR_W = 4;
    localparam int FIFO_DEPTH = 16;

    // ----------------------------------------
    // instruction codes and capture values
    // ----------------------------------------
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
    localparam logic [IR_W-1:0] IR_USER = 4'h2;
    localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;
    localparam logic [DR_W-2:0] DR_CAPTURE_PAD = 7'h00;

    // ----------------------------------------
    // timing counts
    // ----------------------------------------
    localparam logic [2:0] RESET_TMS_RISES = 3'h5;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [3:0] {
        JTP_TLR, JTP_RTI, JTP_SEL_DR, JTP_CAP_DR, JTP_SH_DR, JTP_EX1_DR, JTP_PA_DR,
        JTP_EX2_DR, JTP_UPD_DR, JTP_SEL_IR, JTP_CAP_IR, JTP_SH_IR, JTP_EX1_IR,
        JTP_PA_IR, JTP_EX2_IR, JTP_UPD_IR
    } jtp_state_e;

    // pins after the two-flop synchronisers
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } jtp_pins_s;

    // state of the tap module apart from the check counter and the word buffer
    typedef struct packed {
        jtp_pins_s sync1;
        jtp_pins_s sync2;
        logic tck_d;
        jtp_state_e state;
        logic [IR_W-1:0] ir;
        logic [IR_W-1:0] ir_sh;
        logic [DR_W-1:0] dr;
        logic byp;
        logic tdo;
        logic tdo_en;
        logic push;
    } jtp_tap_s;

endpackage

`default_nettype wire

//--- rtl/jtp_tap.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// word buffer
// ----------------------------------------
module jtp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
    } jtp_fifo_s;

    jtp_fifo_s st;
    jtp_fifo_s next_st;
    logic wr;
    logic rd;

    assign in_ready_o = (st.cnt != CW'(DEPTH));
    assign out_valid_o = (st.cnt != '0);
    assign out_data_o = st.mem[st.rp];
    assign wr = in_valid_i & in_ready_o;
    assign rd = out_valid_o & out_ready_i;

    always_comb begin
        next_st = st;
        if (wr) begin
            next_st.mem[st.wp] = in_data_i;
            next_st.wp = (st.wp == AW'(DEPTH - 1)) ? '0 : st.wp + 1'b1;
        end
        if (rd) begin
            next_st.rp = (st.rp == AW'(DEPTH - 1)) ? '0 : st.rp + 1'b1;
        end
        next_st.cnt = st.cnt + CW'(wr) - CW'(rd);
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// Behaviour
// - tdi sampled on test-clock rise while shifting
// - tdo changes on test-clock fall
// - tdo released unless shifting
// - tap state advances on rise, host sets tms
module jtp_tap (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // test port pins
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    output logic tdo_o,
    output logic tdo_oe_n_o,
    // received words
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    output logic [jtp_pkg::DR_W-1:0] rx_data_o,
    output logic rx_space_o
);
    jtp_pkg::jtp_tap_s st;
    jtp_pkg::jtp_tap_s next_st;
    logic rise;
    logic fall;
    logic user_sel;
    logic fifo_ready;

    // ----------------------------------------
    // edges of the sampled test clock
    // ----------------------------------------
    // the link clock is slow (8 core cycles), so plain sampling finds every edge
    assign rise = st.sync2.tck & ~st.tck_d;
    assign fall = ~st.sync2.tck & st.tck_d;
    assign user_sel = (st.ir == jtp_pkg::IR_USER);

    assign tdo_o = st.tdo;
    assign tdo_oe_n_o = ~st.tdo_en;
    assign rx_space_o = fifo_ready;

    // ----------------------------------------
    // tap controller and shift paths
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_st.sync1 = '{tck: tck_i, tms: tms_i, tdi: tdi_i};
        next_st.sync2 = st.sync1;
        next_st.tck_d = st.sync2.tck;
        next_st.push = 1'b0;
        if (rise) begin
            case (st.state)
                jtp_pkg::JTP_TLR: begin
                    next_st.ir = jtp_pkg::IR_BYPASS;
                    next_st.state = st.sync2.tms ? jtp_pkg::JTP_TLR : jtp_pkg::JTP_RTI;
                end
                jtp_pkg::JTP_RTI: begin
                    next_st.state = st.sync2.tms ? jtp_pkg::JTP_SEL_DR : jtp_pkg::JTP_RTI;
                end
                jtp_pkg::JTP_SEL_DR: begin
                    next_st.state = st.sync2.tms ? jtp_pkg::JTP_SEL_IR : jtp_pkg::JTP_CAP_DR;
                end
                jtp_pkg::JTP_CAP_DR: begin
                    // the host learns in the first bit whether a word will be kept
                    next_st.dr = {jtp_pkg::DR_CAPTURE_PAD, fifo_ready};
                    next_st.byp = 1'b0;
                    next_st.state = st.sync2.tms ? jtp_pkg::JTP_EX1_DR : jtp_pkg::JTP_SH_DR;
                end
                jtp_pkg::JTP_SH_DR: begin
                    next_st.dr = {st.sync2.tdi, st.dr[jtp_pkg::DR_W-1:1]};
                    next_st.byp = st.sync2.tdi;
                    next_st.state = st.sync2.tms ? jtp_pkg::JTP_EX1_DR : jtp_pkg::JTP_SH_DR;
                end
                jtp_pkg::JTP_EX1_DR: begin
                    next_st.state = st.sync2.tms ? jtp_pkg::JTP_UPD_DR : jtp_pkg::JTP_PA_DR;
                end
                jtp_pkg::JTP_PA_DR: begin
                    next_st.state = st.sync2.tms ? jtp_pkg::JTP_EX2_DR : jtp_pkg::JTP_PA_DR;
                end
                jtp_pkg::JTP_EX2_DR: begin
                    next_st.state = st.sync2.tms ? jtp_pkg::JTP_UPD_DR : jtp_pkg::JTP_SH_DR;
                end
                jtp_pkg::JTP_UPD_DR: begin
                    next_st.push = user_sel;
                    next_st.state = st.sync2.tms ? jtp_pkg::JTP_SEL_DR : jtp_pkg::JTP_RTI;
                end
                jtp_pkg::JTP_SEL_IR: begin
                    next_st.state = st.sync2.tms ? jtp_pkg::JTP_TLR : jtp_pkg::JTP_CAP_IR;
                end
                jtp_pkg::JTP_CAP_IR: begin
                    next_st.ir_sh = jtp_pkg::IR_CAPTURE;
                    next_st.state = st.sync2.tms ? jtp_pkg::JTP_EX1_IR : jtp_pkg::JTP_SH_IR;
                end
                jtp_pkg::JTP_SH_IR: begin
                    next_st.ir_sh = {st.sync2.tdi, st.ir_sh[jtp_pkg::IR_W-1:1]};
                    next_st.state = st.sync2.tms ? jtp_pkg::JTP_EX1_IR : jtp_pkg::JTP_SH_IR;
                end
                jtp_pkg::JTP_EX1_IR: begin
                    next_st.state = st.sync2.tms ? jtp_pkg::JTP_UPD_IR : jtp_pkg::JTP_PA_IR;
                end
                jtp_pkg::JTP_PA_IR: begin
                    next_st.state = st.sync2.tms ? jtp_pkg::JTP_EX2_IR : jtp_pkg::JTP_PA_IR;
                end
                jtp_pkg::JTP_EX2_IR: begin
                    next_st.state = st.sync2.tms ? jtp_pkg::JTP_UPD_IR : jtp_pkg::JTP_SH_IR;
                end
                jtp_pkg::JTP_UPD_IR: begin
                    next_st.ir = st.ir_sh;
                    next_st.state = st.sync2.tms ? jtp_pkg::JTP_SEL_DR : jtp_pkg::JTP_RTI;
                end
                default: begin
                    next_st.state = jtp_pkg::JTP_TLR;
                end
            endcase
        end
        if (fall) begin
            // output side moves at the test-clock fall that follows the shift
            next_st.tdo_en = (st.state == jtp_pkg::JTP_SH_DR) ||
                             (st.state == jtp_pkg::JTP_SH_IR);
            if (st.state == jtp_pkg::JTP_SH_IR) begin
                next_st.tdo = st.ir_sh[0];
            end else if (st.state == jtp_pkg::JTP_SH_DR) begin
                next_st.tdo = user_sel ? st.dr[0] : st.byp;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // received word buffer
    // ----------------------------------------
    // a word finished while the buffer is full is dropped; capture shows the space bit
    jtp_fifo #(
        .WIDTH(jtp_pkg::DR_W),
        .DEPTH(jtp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .in_valid_i(st.push),
        .in_ready_o(fifo_ready),
        .in_data_i(st.dr),
        .out_valid_o(rx_valid_o),
        .out_ready_i(rx_ready_i),
        .out_data_o(rx_data_o)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [2:0] tms_hi_cnt;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            tms_hi_cnt <= '0;
        end else if (rise) begin
            if (!st.sync2.tms) begin
                tms_hi_cnt <= '0;
            end else if (tms_hi_cnt != jtp_pkg::RESET_TMS_RISES) begin
                tms_hi_cnt <= tms_hi_cnt + 3'h1;
            end
        end
    end

    property p_five_high_reset;
        @(posedge core_clk_i) disable iff (reset_i)
        rise && st.sync2.tms && (tms_hi_cnt >= jtp_pkg::RESET_TMS_RISES - 3'h1)
        |=> (st.state == jtp_pkg::JTP_TLR);
    endproperty
    a_five_high_reset: assert property (p_five_high_reset) else $error("tap not reset");

    property p_state_on_rise;
        @(posedge core_clk_i) disable iff (reset_i)
        !rise |=> $stable(st.state);
    endproperty
    a_state_on_rise: assert property (p_state_on_rise) else $error("state moved off rise");

    property p_tdo_on_fall;
        @(posedge core_clk_i) disable iff (reset_i)
        $changed(tdo_o) |-> $past(fall);
    endproperty
    a_tdo_on_fall: assert property (p_tdo_on_fall) else $error("tdo moved off fall");

    property p_tdo_released;
        @(posedge core_clk_i) disable iff (reset_i)
        fall && (st.state != jtp_pkg::JTP_SH_DR) && (st.state != jtp_pkg::JTP_SH_IR)
        |=> tdo_oe_n_o ##1 tdo_oe_n_o;
    endproperty
    a_tdo_released: assert property (p_tdo_released) else $error("tdo driven idle");

    property p_tdi_shift;
        @(posedge core_clk_i) disable iff (reset_i)
        rise && (st.state == jtp_pkg::JTP_SH_DR) && user_sel
        |=> (st.dr[jtp_pkg::DR_W-1] == $past(st.sync2.tdi));
    endproperty
    a_tdi_shift: assert property (p_tdi_shift) else $error("tdi not shifted in");

    c_ir_shift: cover property (@(posedge core_clk_i) disable iff (reset_i)
        rise && (st.state == jtp_pkg::JTP_SH_IR));
    c_word_push: cover property (@(posedge core_clk_i) disable iff (reset_i)
        st.push && fifo_ready);
    c_buffer_full: cover property (@(posedge core_clk_i) disable iff (reset_i)
        st.push && !fifo_ready);
endmodule

`default_nettype wire

//--- tb/jtp_host.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// test port host model
// ----------------------------------------
module jtp_host (
    // test port pins
    output var logic tck_o,
    output var logic tms_o,
    output var logic tdi_o,
    input wire logic tdo_i,
    input wire logic tdo_oe_n_i
);
    // idle levels keep the tap inert
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
    end

    // one 80 ns period: pins change only while the clock is low
    // tdo is read during the high phase since the synchronised fall lags the pin
    task automatic tick(input logic m, input logic d, output logic o, output logic oen);
        tms_o = m;
        tdi_o = d;
        #50;
        tck_o = 1'b1;
        #20;
        // nothing pulls tdo, so a released pin reads back inverted here
        o = tdo_oe_n_i ? ~tdo_i : tdo_i;
        oen = tdo_oe_n_i;
        #10;
        tck_o = 1'b0;
    endtask

    task automatic reset_tap();
        logic o;
        logic e;
        repeat (jtp_pkg::RESET_TMS_RISES) tick(1'b1, 1'b1, o, e);
        tick(1'b0, 1'b1, o, e);
    endtask

    // one scan from run-test-idle and back, lsb first; drv stays high if tdo drove throughout
    task automatic scan(input logic ir, input int n, input logic [7:0] din,
                        output logic [7:0] dout, output logic drv);
        logic o;
        logic e;
        dout = 8'h00;
        drv = 1'b1;
        tick(1'b1, 1'b1, o, e);
        if (ir) begin
            tick(1'b1, 1'b1, o, e);
        end
        tick(1'b0, 1'b1, o, e);
        tick(1'b0, 1'b1, o, e);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], o, e);
            dout[i] = o;
            drv = drv & ~e;
        end
        tick(1'b1, 1'b1, o, e);
        tick(1'b0, 1'b1, o, e);
        tms_o = 1'b1;
        tdi_o = 1'b1;
    endtask
endmodule

`default_nettype wire

//--- tb/tb_jtag_tap_pin_interface.sv
`timescale 1ns/1ns
`default_nettype none

module tb_jtag_tap_pin_interface;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic rx_ready_i = 1'b0;
    wire logic tck;
    wire logic tms;
    wire logic tdi;
    logic tdo_o;
    logic tdo_oe_n_o;
    logic rx_valid_o;
    logic rx_space_o;
    logic [jtp_pkg::DR_W-1:0] rx_data_o;
    int mismatches = 0;
    int total_checks = 0;
    logic [7:0] q[$];
    logic [7:0] o;
    logic [7:0] d;
    logic e;

    always #5 core_clk_i = ~core_clk_i;

    jtp_tap uut (
        .core_clk_i(core_clk_i), .reset_i(reset_i),
        .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o),
        .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i), .rx_data_o(rx_data_o),
        .rx_space_o(rx_space_o)
    );

    jtp_host host (
        .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_o), .tdo_oe_n_i(tdo_oe_n_o)
    );

    // ----------------------------------------
    // checking and verdict
    // ----------------------------------------
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // model: a word is kept only while fewer than 16 wait, capture bit 0 reports space
    task automatic user_scan(input logic [7:0] din);
        logic [7:0] exp;
        exp = {7'h00, q.size() < jtp_pkg::FIFO_DEPTH};
        host.scan(1'b0, 8, din, o, e);
        cmp("dr capture", exp, o);
        cmp("tdo driven in shift", 8'h01, {7'h00, e});
        if (q.size() < jtp_pkg::FIFO_DEPTH) begin
            q.push_back(din);
        end
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(58800));
        repeat (5) @(posedge core_clk_i);
        @(negedge core_clk_i);
        reset_i = 1'b0;
        cmp("oe_n in reset", 8'h01, {7'h00, tdo_oe_n_o});
        cmp("valid in reset", 8'h00, {7'h00, rx_valid_o});
        host.reset_tap();
        host.scan(1'b1, 4, 8'h0F, o, e);
        cmp("ir capture", 8'h01, o);
        d = 8'($urandom);
        host.scan(1'b0, 8, d, o, e);
        cmp("bypass path", {d[6:0], 1'b0}, o);
        #200;
        cmp("oe_n idle", 8'h01, {7'h00, tdo_oe_n_o});
        host.scan(1'b1, 4, 8'h02, o, e);
        cmp("ir capture", 8'h01, o);
        repeat (18) user_scan(8'($urandom));
        cmp("space when full", 8'h00, {7'h00, rx_space_o});
        // drain with a stalling reader; a word is taken at the next rise when both are high
        for (int k = 0; k < 2000 && q.size() > 0; k++) begin
            @(negedge core_clk_i);
            rx_ready_i = 1'($urandom);
            if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1) begin
                cmp("rx word", q.pop_front(), rx_data_o);
            end
        end
        @(negedge core_clk_i);
        rx_ready_i = 1'b0;
        @(negedge core_clk_i);
        cmp("valid when empty", 8'h00, {7'h00, rx_valid_o});
        cmp("words left", 8'h00, 8'(q.size()));
        user_scan(8'($urandom));
        repeat (2) @(negedge core_clk_i);
        cmp("last word", q.pop_front(), rx_data_o);
        // five high rises from run-test-idle must drop the user code back to bypass
        host.reset_tap();
        d = 8'($urandom);
        host.scan(1'b0, 8, d, o, e);
        cmp("bypass after reset", {d[6:0], 1'b0}, o);
        close_out();
    end

    initial begin
        #400000;
        mismatches++;
        close_out();
    end
endmodule

`default_nettype wire
